// >>> src/ddr_io_element.sv
`timescale 1ns/1ps
// Behaviour
// RL1: six registers and one latch per element
// RL2: delayed enable adds half-cycle high-z preamble
// RL3: tristate control active low, optionally high
// RL4: primary enable general, delayed for strobes
// RL5: select undelayed or half-cycle delayed enable
// RL6: every entering control optionally inverted locally; the mask covers only oeReq, postambleGate, delayedOeSel and combOe
// RL7: combinational output and tristate paths offered
// RL8: rise loads A, fall B, latch open high
// RL9: user inverts strobe except for QDRII
// RL10: inverted strobe keeps final read word
// RL11: inversion swaps A and latch on outputs
// RL12: output clock lags system clock 90 degrees
// RL13: complementary strobe used only for QDRII
// RL14: strobe pin enable off for RLDRAM/QDRII
// RL15: strobe data inputs tied zero and one
// RL16: system clock strobes, shifted clock data
// RL17: side banks use separate read clock source
// RL18: shifted strobe also routed to core
// RL19: postamble gate forces capture clock low
// RL20: delayed enable register on opposite edge
module ddr_io_element (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic strobeIn,
   input wire logic compStrobeIn,
   input wire logic readClkIn,
   input wire logic sysClkIn,
   input wire logic dataPinIn,
   input wire logic invertStrobe,
   input wire logic useCompStrobe,
   input wire logic sideBank,
   input wire logic postambleGate,
   input wire logic [ddr_io_element_pkg::CTL_WIDTH-1:0] ctlInvert,
   input wire logic oeReq,
   input wire logic delayedOeSel,
   input wire logic oeActiveHigh,
   input wire logic strobeOeOff,
   input wire logic dataInHigh,
   input wire logic dataInLow,
   input wire logic combOutSel,
   input wire logic combOutData,
   input wire logic combOeSel,
   input wire logic combOe,
   output logic capturedHigh,
   output logic capturedLow,
   output logic strobeToCore,
   output logic dataPinOut,
   output logic dataPinOe,
   output logic triCtl
);

   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   logic strobeS1, strobeS2, compS1, compS2, readS1, readS2;
   logic sysS1, sysS2, dqS1, dqS2;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         strobeS1 <= ddr_io_element_pkg::RST_BIT;
         strobeS2 <= ddr_io_element_pkg::RST_BIT;
         compS1 <= ddr_io_element_pkg::RST_BIT;
         compS2 <= ddr_io_element_pkg::RST_BIT;
         readS1 <= ddr_io_element_pkg::RST_BIT;
         readS2 <= ddr_io_element_pkg::RST_BIT;
         sysS1 <= ddr_io_element_pkg::RST_BIT;
         sysS2 <= ddr_io_element_pkg::RST_BIT;
         dqS1 <= ddr_io_element_pkg::RST_BIT;
         dqS2 <= ddr_io_element_pkg::RST_BIT;
      end else begin
         strobeS1 <= strobeIn;
         strobeS2 <= strobeS1;
         compS1 <= compStrobeIn;
         compS2 <= compS1;
         readS1 <= readClkIn;
         readS2 <= readS1;
         sysS1 <= sysClkIn;
         sysS2 <= sysS1;
         dqS1 <= dataPinIn;
         dqS2 <= dqS1;
      end
   end

   // ----------------------------------------
   // local control inversion
   // ----------------------------------------
   logic [ddr_io_element_pkg::CTL_WIDTH-1:0] ctlRaw, ctlEff;
   assign ctlRaw = {combOe, delayedOeSel, postambleGate, oeReq};

   genvar gi;
   generate
      for (gi = 0; gi < ddr_io_element_pkg::CTL_WIDTH; gi = gi + 1) begin : g_inv
         assign ctlEff[gi] = ctlRaw[gi] ^ ctlInvert[gi]; // RL6
      end
   endgenerate

   // ----------------------------------------
   // capture clock
   // ----------------------------------------
   function automatic ddr_io_element_pkg::capSrc_t pickSrc(input logic side, input logic comp);
      pickSrc = side ? ddr_io_element_pkg::CAP_READ_CLK :
         (comp ? ddr_io_element_pkg::CAP_COMP_STROBE : ddr_io_element_pkg::CAP_STROBE);
   endfunction

   ddr_io_element_pkg::capSrc_t capSrc;
   logic capRaw, capLvl, capPrev, capRise, capFall;

   always_comb begin
      capSrc = pickSrc(sideBank, useCompStrobe);
      case (capSrc)
         ddr_io_element_pkg::CAP_READ_CLK: capRaw = readS2; // RL17
         ddr_io_element_pkg::CAP_COMP_STROBE: capRaw = compS2; // RL13
         ddr_io_element_pkg::CAP_STROBE: capRaw = strobeS2;
         default: capRaw = strobeS2;
      endcase
   end

   // gate after inversion so a glitchy postamble never clocks capture
   assign capLvl = (capRaw ^ invertStrobe) & ~ctlEff[ddr_io_element_pkg::CTL_POSTAMBLE]; // RL19
   assign capRise = capLvl & ~capPrev;
   assign capFall = ~capLvl & capPrev;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         capPrev <= ddr_io_element_pkg::RST_BIT;
      end else begin
         capPrev <= capLvl;
      end
   end

   // ----------------------------------------
   // input registers and latch
   // ----------------------------------------
   logic regA, regB, latchC;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         regA <= ddr_io_element_pkg::RST_BIT;
      end else if (capRise) begin
         regA <= dqS2; // RL8
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         regB <= ddr_io_element_pkg::RST_BIT;
      end else if (capFall) begin
         regB <= dqS2; // RL8
      end
   end

   // transparent while the capture clock is high; with the strobe
   // inverted it opens on the low phase that carries the last word
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         latchC <= ddr_io_element_pkg::RST_BIT;
      end else if (capLvl) begin
         latchC <= regB; // RL8 RL10
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         capturedHigh <= ddr_io_element_pkg::RST_BIT;
         capturedLow <= ddr_io_element_pkg::RST_BIT;
      end else begin
         capturedHigh <= invertStrobe ? latchC : regA; // RL11
         capturedLow <= invertStrobe ? regA : latchC; // RL11
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         strobeToCore <= ddr_io_element_pkg::RST_BIT;
      end else begin
         strobeToCore <= capLvl; // RL18
      end
   end

   // ----------------------------------------
   // output data registers
   // ----------------------------------------
   logic sysPrev, sysRise, sysFall, outHigh, outLow;
   assign sysRise = sysS2 & ~sysPrev;
   assign sysFall = ~sysS2 & sysPrev;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sysPrev <= ddr_io_element_pkg::RST_BIT;
      end else begin
         sysPrev <= sysS2;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         outHigh <= ddr_io_element_pkg::RST_BIT;
         outLow <= ddr_io_element_pkg::RST_BIT;
      end else if (sysRise) begin
         outHigh <= dataInHigh; // RL1
         outLow <= dataInLow; // RL1
      end
   end

   // ----------------------------------------
   // output enable registers
   // ----------------------------------------
   logic oeA, oeB, next_oe;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         oeA <= ddr_io_element_pkg::RST_BIT;
      end else if (sysRise) begin
         oeA <= ctlEff[ddr_io_element_pkg::CTL_OE]; // RL4
      end
   end

   // opposite edge, so it trails the primary by exactly half a cycle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         oeB <= ddr_io_element_pkg::RST_BIT;
      end else if (sysFall) begin
         oeB <= oeA; // RL20 RL4
      end
   end

   always_comb begin
      if (strobeOeOff) begin
         next_oe = 1'h0; // RL14
      end else if (combOeSel) begin
         next_oe = ctlEff[ddr_io_element_pkg::CTL_COMB_OE]; // RL7
      end else if (ctlEff[ddr_io_element_pkg::CTL_DELAY_SEL]) begin
         // start waits for the delayed copy, end follows the primary
         next_oe = oeA & oeB; // RL2 RL5
      end else begin
         next_oe = oeA; // RL5
      end
   end

   // ----------------------------------------
   // pin drive
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         dataPinOut <= ddr_io_element_pkg::RST_BIT;
      end else if (combOutSel) begin
         dataPinOut <= combOutData; // RL7
      end else begin
         dataPinOut <= sysS2 ? outHigh : outLow;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         dataPinOe <= ddr_io_element_pkg::RST_BIT;
         triCtl <= 1'h1;
      end else begin
         dataPinOe <= next_oe;
         triCtl <= oeActiveHigh ? next_oe : ~next_oe; // RL3
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence capRiseSeq;
      capRise;
   endsequence

   sequence sysFallSeq;
      sysFall;
   endsequence

   AST_RISE_LOADS_A: assert property (@(posedge ref_clk) disable iff (!rstn) // RL8
      capRiseSeq |=> (regA == $past(dqS2)))
      else $error("rise did not load register A");

   AST_FALL_LOADS_B: assert property (@(posedge ref_clk) disable iff (!rstn) // RL8
      capFall |=> (regB == $past(dqS2)))
      else $error("fall did not load register B");

   AST_LATCH_HOLDS: assert property (@(posedge ref_clk) disable iff (!rstn) // RL10
      !capLvl |=> $stable(latchC))
      else $error("latch moved while closed");

   AST_SWAP_OUT: assert property (@(posedge ref_clk) disable iff (!rstn) // RL11
      invertStrobe |=> (capturedHigh == $past(latchC)) && (capturedLow == $past(regA)))
      else $error("inverted outputs not swapped");

   AST_POSTAMBLE: assert property (@(posedge ref_clk) disable iff (!rstn) // RL19
      ctlEff[ddr_io_element_pkg::CTL_POSTAMBLE] |=> !strobeToCore)
      else $error("gated strobe reached core");

   AST_DELAY_REG: assert property (@(posedge ref_clk) disable iff (!rstn) // RL20
      sysFallSeq |=> (oeB == $past(oeA)))
      else $error("delayed enable missed falling edge");

   AST_PREAMBLE: assert property (@(posedge ref_clk) disable iff (!rstn) // RL2
      (!strobeOeOff && !combOeSel && ctlEff[ddr_io_element_pkg::CTL_DELAY_SEL] && !oeB)
      |=> !dataPinOe)
      else $error("pin driven before delayed enable");

   AST_STROBE_OFF: assert property (@(posedge ref_clk) disable iff (!rstn) // RL14
      strobeOeOff |=> !dataPinOe)
      else $error("strobe pin driven while forced off");

   AST_TRI_POLARITY: assert property (@(posedge ref_clk) disable iff (!rstn) // RL3
      !$past(oeActiveHigh) |-> (triCtl == !dataPinOe))
      else $error("tristate polarity wrong");

   AST_COMB_OUT: assert property (@(posedge ref_clk) disable iff (!rstn) // RL7
      combOutSel |=> (dataPinOut == $past(combOutData)))
      else $error("combinational output path ignored");

endmodule

// >>> pkg/ddr_io_element_pkg.sv
package ddr_io_element_pkg;
   // synchroniser depth for every pin-side input
   localparam int SYNC_STAGES = 2;
   // bench period of the sampled link clocks, in ns, and of ref_clk
   localparam int LINK_PERIOD_NS = 200;
   localparam int REF_PERIOD_NS = 25;
   localparam int LINK_HALF_CYCLES = (LINK_PERIOD_NS / REF_PERIOD_NS) / 2;
   // positions in the local control inversion mask
   localparam int CTL_WIDTH = 4;
   localparam int CTL_OE = 0;
   localparam int CTL_POSTAMBLE = 1;
   localparam int CTL_DELAY_SEL = 2;
   localparam int CTL_COMB_OE = 3;
   // reset values
   localparam logic RST_BIT = 1'h0;
   localparam logic [CTL_WIDTH-1:0] RST_CTL = 4'h0;
   // capture clock sources
   typedef enum {CAP_STROBE, CAP_COMP_STROBE, CAP_READ_CLK} capSrc_t;
endpackage

// >>> verification/ddr_mem_model.sv
`timescale 1ns/1ps
module ddr_mem_model (
   output logic strobe,
   output logic compStrobe,
   output logic readClk,
   output logic dq
);
   // ----------
   // read burst
   // ----------
   // one strobe feeds every capture source so each mode sees the same burst
   assign compStrobe = ~strobe;
   assign readClk = strobe;
   initial begin
      strobe = 1'h1;
      dq = 1'h0;
   end
   // data moves a quarter period ahead of each strobe edge
   task automatic burst(input logic [7:0] w, input int n);
      strobe = 1'h0;
      #100;
      for (int i = 0; i < n; i++) begin
         dq = w[i];
         #50 strobe = ~strobe;
         #50;
      end
      // hold time over: a released line no longer shows its last level
      dq = ~dq;
      #50;
   endtask
   task automatic idle();
      strobe = ~strobe;
   endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
   $display("ERROR %0t mismatch got %b exp %b", $time, a, b); end end
module tb;
   logic ref_clk = 1'h0;
   logic rstn = 1'h0;
   logic sysClkIn = 1'h0;
   logic strobeIn, compStrobeIn, readClkIn, dataPinIn;
   logic invertStrobe = 1'h0, useCompStrobe = 1'h0, sideBank = 1'h0;
   logic oeActiveHigh = 1'h0, strobeOeOff = 1'h0, dataInHigh = 1'h0, dataInLow = 1'h0;
   logic combOutSel = 1'h0, combOutData = 1'h0, combOeSel = 1'h0;
   logic [ddr_io_element_pkg::CTL_WIDTH-1:0] ctlInvert = 4'h0;
   logic gate = 1'h1, oe = 1'h0, dsel = 1'h0, cOe = 1'h0;
   logic capturedHigh, capturedLow, strobeToCore, dataPinOut, dataPinOe, triCtl;
   int n_errors = 0;
   int tests_run = 0;
   always #12.5 ref_clk = ~ref_clk;
   // write clock lags a notional system clock at time zero by a quarter period;
   // the extra 7 ns keep its edges off both ref_clk edges
   initial begin
      #57;
      forever #100 sysClkIn = ~sysClkIn;
   end
   ddr_mem_model i_ddr_mem_model (.strobe(strobeIn), .compStrobe(compStrobeIn),
      .readClk(readClkIn), .dq(dataPinIn));
   // controls are driven raw, pre-inverted so the element sees the wanted level
   ddr_io_element i_ddr_io_element (.ref_clk, .rstn, .strobeIn, .compStrobeIn, .readClkIn,
      .sysClkIn, .dataPinIn, .invertStrobe, .useCompStrobe, .sideBank,
      .postambleGate(gate ^ ctlInvert[ddr_io_element_pkg::CTL_POSTAMBLE]), .ctlInvert,
      .oeReq(oe ^ ctlInvert[ddr_io_element_pkg::CTL_OE]),
      .delayedOeSel(dsel ^ ctlInvert[ddr_io_element_pkg::CTL_DELAY_SEL]), .oeActiveHigh,
      .strobeOeOff, .dataInHigh, .dataInLow, .combOutSel, .combOutData, .combOeSel,
      .combOe(cOe ^ ctlInvert[ddr_io_element_pkg::CTL_COMB_OE]), .capturedHigh,
      .capturedLow, .strobeToCore, .dataPinOut, .dataPinOe, .triCtl);
   // ------
   // checks
   // ------
   function automatic logic [1:0] exp_cap(input logic [7:0] w, input logic p, input logic inv);
      logic a;
      logic l;
      a = p ? w[3] : w[2];
      l = p ? w[2] : w[1];
      return inv ? {l, a} : {a, l};
   endfunction
   task automatic stop_test();
      $display("errors %0d comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // --------
   // stimulus
   // --------
   task automatic rd(input int src, input logic inv);
      logic [7:0] w;
      logic p;
      logic [1:0] e;
      w = 8'($urandom);
      p = inv ^ (src == 1);
      e = exp_cap(w, p, inv);
      @(negedge ref_clk);
      ctlInvert = 4'($urandom);
      invertStrobe = inv;
      // side-bank mode must win whatever the other select says
      useCompStrobe = (src == 1) | (src == 2 && 1'($urandom));
      sideBank = (src == 2);
      gate = 1'h0;
      i_ddr_mem_model.burst(w, 4);
      repeat (4) @(negedge ref_clk);
      `CHK(strobeToCore, p)
      gate = 1'h1;
      repeat (6) @(negedge ref_clk);
      i_ddr_mem_model.idle();
      repeat (8) @(negedge ref_clk);
      `CHK(strobeToCore, 1'h0)
      `CHK(capturedHigh, e[1])
      `CHK(capturedLow, e[0])
      $display("read test done");
   endtask
   task automatic wr(input logic ds, input logic off);
      logic hi;
      logic e;
      // a strobe pin has its high half tied to one and its low half to zero
      hi = off | 1'($urandom);
      e = ~ds & ~off;
      @(negedge sysClkIn);
      @(negedge ref_clk);
      ctlInvert = 4'($urandom);
      dsel = ds;
      strobeOeOff = off;
      oeActiveHigh = 1'($urandom);
      dataInHigh = hi;
      dataInLow = ~hi;
      oe = 1'h1;
      @(posedge sysClkIn);
      #110 `CHK(dataPinOut, hi)
      #50 `CHK(dataPinOe, e)
      `CHK(triCtl, e ~^ oeActiveHigh)
      #50 `CHK(dataPinOut, ~hi)
      #30 `CHK(dataPinOe, ~off)
      @(negedge ref_clk) oe = 1'h0;
      #400 `CHK(dataPinOe, 1'h0)
      $display("write test done");
   endtask
   task automatic comb();
      logic d;
      logic c;
      d = 1'($urandom);
      c = 1'($urandom);
      @(negedge ref_clk);
      ctlInvert = 4'($urandom);
      strobeOeOff = 1'h0;
      combOutSel = 1'h1;
      combOutData = d;
      combOeSel = 1'h1;
      cOe = c;
      repeat (4) @(negedge ref_clk);
      `CHK(dataPinOut, d)
      `CHK(dataPinOe, c)
      `CHK(triCtl, c ~^ oeActiveHigh)
      combOutSel = 1'h0;
      combOeSel = 1'h0;
      $display("combinational test done");
   endtask
   initial begin
      void'($urandom(32'h5dfdd289));
      repeat (2) @(negedge ref_clk);
      `CHK(triCtl, 1'h1)
      `CHK(dataPinOe, 1'h0)
      @(negedge ref_clk);
      rstn = 1'h1;
      for (int s = 0; s < 3; s++) begin
         rd(s, 1'h1);
         rd(s, 1'h0);
      end
      wr(1'h0, 1'h0);
      wr(1'h1, 1'h0);
      wr(1'h0, 1'h1);
      wr(1'h1, 1'h1);
      repeat (3) comb();
      stop_test();
   end
   // a hang costs a mismatch; the run needs about a tenth of this span
   initial begin
      #100000;
      n_errors++;
      stop_test();
   end
endmodule
